// file: rtl/rx_crd_pkg.sv
// constants and types shared by the asynchronous receive front end
// assumes a single reference clock domain; no software-visible registers
`default_nettype none

package rx_crd_pkg;

  // ==========================================================
  // receive sampling mode codes
  typedef logic [1:0] mode_type;
  localparam mode_type MODE_NORMAL = 2'h0;
  localparam mode_type MODE_DOUBLE = 2'h1;

  // ==========================================================
  // sample counting within one bit period
  typedef logic [4:0] count_type;
  localparam count_type SAMPLES_NORMAL    = 5'h10;
  localparam count_type SAMPLES_DOUBLE    = 5'h08;
  localparam count_type FIRST_VOTE_NORMAL = 5'h08;
  localparam count_type FIRST_VOTE_DOUBLE = 5'h04;
  localparam count_type VOTE_LAST_OFFSET  = 5'h02;
  localparam count_type COUNT_FIRST       = 5'h01;
  localparam count_type COUNT_ONE         = 5'h01;

  // ==========================================================
  // frame size
  typedef logic [3:0] size_type;
  localparam size_type DATA_BITS_MIN = 4'h5;
  localparam size_type DATA_BITS_MAX = 4'h9;
  localparam size_type FRAME_BITS_MAX = 4'hA;
  localparam int       CHAR_WIDTH = 9;
  typedef logic [CHAR_WIDTH-1:0] char_type;

  // ==========================================================
  // receiver states
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_type;

endpackage : rx_crd_pkg

`default_nettype wire

// file: rtl/sample_if.sv
// carries the sample strobe and the synchronised receive line
// assumes both producers and the consumer share ref_clk
`default_nettype none

interface sample_if;
  logic tick;
  logic line;

  modport tick_src (output tick);
  modport line_src (output line);
  modport sink     (input tick, input line);
endinterface : sample_if

`default_nettype wire

// file: rtl/rx_sample_tick.sv
// sample strobe generator: one tick every baud_divider+1 clocks
// assumes baud_divider is held stable while a frame is received
`default_nettype none

module rx_sample_tick #(
  parameter int DIV_WIDTH = 16
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // divider setting
  input  wire logic [DIV_WIDTH-1:0] baud_divider,
  // strobe out
  sample_if.tick_src                smp
);

  logic [DIV_WIDTH-1:0] div_reg;

  // ==========================================================
  // down counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
    end else if (div_reg == '0) begin
      div_reg <= baud_divider;
    end else begin
      div_reg <= div_reg - 1'b1;
    end
  end

  // ==========================================================
  // registered strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      smp.tick <= 1'b0;
    end else begin
      smp.tick <= (div_reg == '0);
    end
  end

endmodule : rx_sample_tick

`default_nettype wire

// file: rtl/rx_line_sync.sv
// receive pin synchroniser: three stages, level changes once stages two and three agree
// assumes the pin idles high
`default_nettype none

module rx_line_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // pin
  input  wire logic rxd_pin,
  // synchronised level
  sample_if.line_src smp
);

  logic meta_reg;
  logic sync2_reg;
  logic sync3_reg;

  // ==========================================================
  // synchroniser chain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg  <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
    end else begin
      meta_reg  <= rxd_pin;
      sync2_reg <= meta_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // ==========================================================
  // accepted level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      smp.line <= 1'b1;
    end else if (sync2_reg == sync3_reg) begin
      smp.line <= sync3_reg;
    end
  end

endmodule : rx_line_sync

`default_nettype wire

// file: rtl/async_rx_clock_data_recovery.sv
// asynchronous receive clock and data recovery
// assumes a 200 MHz ref_clk and configuration inputs held stable during a frame
//
// Functional notes
// RQ1: normal mode takes sixteen samples per bit for start detection and bit recovery.
// RQ2: mode code 0x01 selects double speed with eight samples per bit.
// RQ3: with the same divider, double speed doubles the baud rate since the sample rate is unchanged.
// RQ4: start detection begins on a falling edge from idle, the first low sample being sample one.
// RQ5: the start bit is validated on samples 8, 9, 10 (normal) or 4, 5, 6 (double speed).
// RQ6: two or more low validation samples accept the start bit and lock the bit timing to it.
// RQ7: fewer than two low validation samples reject the start bit, and every frame is checked anew.
// RQ8: each data and parity bit is the majority of its three centre samples.
// RQ9: only the first stop bit is evaluated; further stop bits are ignored.
// RQ10: a low voted first stop bit sets the frame error flag of that character.
// RQ11: in normal mode a new start edge is seen right after the last stop vote sample.
// RQ12: in double speed the next first low sample counts from the first sample after the stop votes.
// RQ13: the vote window starts at sample 8 (middle 9) normal, and sample 4 (middle 5) double speed.
// RQ14: the frame length is character size plus parity bit, from five to ten bits.
// RQ15: in normal mode each side should keep its rate error within 3.0 to 1.5 percent by frame length.
// RQ16: in double speed each side should keep its rate error within 2.5 to 1.0 percent by frame length.
// RQ17: after the first stop bit the character and flags are delivered and the line is watched again.
`default_nettype none

module async_rx_clock_data_recovery #(
  parameter int DIV_WIDTH = 16
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // receive pin
  input  wire logic                  rxd_pin,
  // configuration
  input  wire logic                  rx_enable,
  input  wire rx_crd_pkg::mode_type  receive_sampling_mode_field,
  input  wire logic [DIV_WIDTH-1:0]  baud_divider,
  input  wire rx_crd_pkg::size_type  data_bits,
  input  wire logic                  parity_enable,
  // received character
  output logic                       rx_valid,
  output rx_crd_pkg::char_type       rx_data,
  output logic                       rx_parity,
  output logic                       rx_frame_error,
  // status
  output logic                       start_rejected,
  output logic                       rx_busy
);

  import rx_crd_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj3

  function automatic count_type samples_per_bit(input logic dbl);
    return dbl ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
  endfunction : samples_per_bit

  function automatic count_type first_vote(input logic dbl);
    return dbl ? FIRST_VOTE_DOUBLE : FIRST_VOTE_NORMAL;
  endfunction : first_vote

  // ==========================================================
  // sample strobe and line
  sample_if smp ();

  rx_sample_tick #(
    .DIV_WIDTH    (DIV_WIDTH)
  ) u_tick (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .baud_divider (baud_divider),
    .smp          (smp.tick_src)
  );

  rx_line_sync u_sync (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .rxd_pin      (rxd_pin),
    .smp          (smp.line_src)
  );

  // ==========================================================
  // state
  rx_state_type state_reg;
  rx_state_type state_next;
  logic         double_reg;
  count_type    cnt_reg;
  count_type    cnt_next;
  logic [1:0]   vote_reg;
  size_type     bit_idx_reg;
  size_type     data_len_reg;
  size_type     frame_len_reg;
  char_type     data_reg;
  logic         parity_reg;
  logic         line_prev_reg;

  // ==========================================================
  // timing decode
  count_type spb;
  count_type sf;
  count_type sl;
  count_type cnt_step;
  logic      active;
  logic      falling;
  logic      in_window;
  logic      decide;
  logic      bit_end;
  logic      vote_bit;
  logic      accept;
  logic      last_bit;
  size_type  data_len_clamp;

  always_comb begin
    spb       = samples_per_bit(double_reg);              // RQ1 RQ2 RQ3
    sf        = first_vote(double_reg);                   // RQ13
    sl        = sf + VOTE_LAST_OFFSET;                    // RQ5 RQ13
    cnt_step  = (cnt_reg == spb) ? COUNT_FIRST : cnt_reg + COUNT_ONE;
    active    = (state_reg != RX_IDLE);
    falling   = smp.tick && line_prev_reg && !smp.line;   // RQ4
    in_window = (cnt_step >= sf) && (cnt_step <= sl);
    decide    = smp.tick && active && (cnt_step == sl);
    bit_end   = smp.tick && active && (cnt_reg == spb);
    vote_bit  = maj3({vote_reg, smp.line});               // RQ8
    accept    = !vote_bit;                                // RQ6
    last_bit  = (bit_idx_reg == frame_len_reg - 4'h1);
  end

  // frame length: clamp the character size, then add the parity bit
  always_comb begin
    if (data_bits < DATA_BITS_MIN) begin
      data_len_clamp = DATA_BITS_MIN;
    end else if (data_bits > DATA_BITS_MAX) begin
      data_len_clamp = DATA_BITS_MAX;
    end else begin
      data_len_clamp = data_bits;
    end
  end

  // ==========================================================
  // line level at the previous tick; resets high so release gives no false edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_prev_reg <= 1'b1;
    end else if (smp.tick) begin
      line_prev_reg <= smp.line;                          // RQ4 RQ11 RQ12
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RX_IDLE: begin
        if (rx_enable && falling) begin
          state_next = RX_START;                          // RQ4
        end
      end
      RX_START: begin
        if (decide && !accept) begin
          state_next = RX_IDLE;                           // RQ7
        end else if (bit_end) begin
          state_next = RX_DATA;                           // RQ6
        end
      end
      RX_DATA: begin
        if (bit_end && last_bit) begin
          state_next = RX_STOP;                           // RQ14
        end
      end
      RX_STOP: begin
        if (decide) begin
          state_next = RX_IDLE;                           // RQ9 RQ11 RQ12 RQ17
        end
      end
      default: begin
        state_next = RX_IDLE;
      end
    endcase
    if (!rx_enable) begin
      state_next = RX_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= RX_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // frame setup latched at the first low sample
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      double_reg    <= 1'b0;
      data_len_reg  <= DATA_BITS_MAX;
      frame_len_reg <= FRAME_BITS_MAX;
    end else if (state_reg == RX_IDLE && state_next == RX_START) begin
      double_reg    <= (receive_sampling_mode_field == MODE_DOUBLE);    // RQ2
      data_len_reg  <= data_len_clamp;
      frame_len_reg <= data_len_clamp + {3'h0, parity_enable};          // RQ14
    end
  end

  // ==========================================================
  // sample counter
  always_comb begin
    cnt_next = cnt_reg;
    if (state_reg == RX_IDLE) begin
      cnt_next = COUNT_FIRST;                             // RQ4
    end else if (smp.tick) begin
      cnt_next = cnt_step;                                // RQ6
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= COUNT_FIRST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================
  // vote samples; the third comes straight from the line
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vote_reg <= 2'h3;
    end else if (smp.tick && active && in_window) begin
      vote_reg <= {vote_reg[0], smp.line};                // RQ8
    end
  end

  // ==========================================================
  // bit index within the frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_idx_reg <= '0;
    end else if (state_reg != RX_DATA) begin
      bit_idx_reg <= '0;
    end else if (bit_end) begin
      bit_idx_reg <= bit_idx_reg + 4'h1;
    end
  end

  // ==========================================================
  // character assembly, least significant bit first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_reg   <= '0;
      parity_reg <= 1'b0;
    end else if (state_reg == RX_IDLE) begin
      data_reg   <= '0;
      parity_reg <= 1'b0;
    end else if (state_reg == RX_DATA && decide) begin
      if (bit_idx_reg < data_len_reg) begin
        data_reg[bit_idx_reg] <= vote_bit;                // RQ8
      end else begin
        parity_reg <= vote_bit;                           // RQ8
      end
    end
  end

  // ==========================================================
  // delivery
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_valid       <= 1'b0;
      rx_data        <= '0;
      rx_parity      <= 1'b0;
      rx_frame_error <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (state_reg == RX_STOP && decide && rx_enable) begin
        rx_valid       <= 1'b1;                           // RQ17
        rx_data        <= data_reg;
        rx_parity      <= parity_reg;
        rx_frame_error <= !vote_bit;                      // RQ10
      end
    end
  end

  // ==========================================================
  // status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      start_rejected <= 1'b0;
    end else begin
      start_rejected <= (state_reg == RX_START) && decide && !accept;   // RQ7
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_busy <= 1'b0;
    end else begin
      rx_busy <= (state_next != RX_IDLE);
    end
  end

  // the fixed vote window sets the rate tolerance each side must respect: RQ15 RQ16

endmodule : async_rx_clock_data_recovery

`default_nettype wire

// file: sim/serial_tx_model.sv
// remote asynchronous transmitter driving the receive pin
// assumes the bench sets bits and timing before pulsing go
`default_nettype none

module serial_tx_model (
  // clock
  input  wire logic        ref_clk,
  // request
  input  wire logic        go,
  input  wire logic [23:0] bits,
  input  wire logic [23:0] short_mask,
  input  wire logic [4:0]  nbits,
  input  wire logic [7:0]  bit_clks,
  input  wire logic [7:0]  short_clks,
  // line
  output var  logic        txd,
  output var  logic        busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // bit shifter, one level per bit period, idle high
  initial begin
    txd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < nbits; i++) begin
          txd <= bits[i];
          repeat (short_mask[i] ? short_clks : bit_clks) @(posedge ref_clk);
        end
        txd <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule : serial_tx_model

`default_nettype wire

// file: sim/async_rx_monitor.sv
// port assertions for the receive front end
// assumes it is bound onto the receiver top module
`default_nettype none

module async_rx_monitor #(
  parameter int DIV_WIDTH = 16
) (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst,
  // inputs
  input wire logic                 rxd_pin,
  input wire logic                 rx_enable,
  input wire rx_crd_pkg::mode_type receive_sampling_mode_field,
  input wire logic [DIV_WIDTH-1:0] baud_divider,
  input wire rx_crd_pkg::size_type data_bits,
  input wire logic                 parity_enable,
  // outputs
  input wire logic                 rx_valid,
  input wire rx_crd_pkg::char_type rx_data,
  input wire logic                 rx_parity,
  input wire logic                 rx_frame_error,
  input wire logic                 start_rejected,
  input wire logic                 rx_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import rx_crd_pkg::*;

  // ==========================================================
  // clocks since the pin was last low
  logic [3:0] low_age_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      low_age_reg <= 4'hF;
    else if (!rxd_pin)
      low_age_reg <= 4'h0;
    else if (low_age_reg != 4'hF)
      low_age_reg <= low_age_reg + 4'h1;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence frame_open;
    $rose(rx_busy);
  endsequence
  sequence frame_closed;
    ##[1:900] !rx_busy;
  endsequence

  // ==========================================================
  // assertions
  chk_valid_single: assert property (rx_valid |=> !rx_valid)
    else $error("rx_valid longer than one cycle");
  chk_reject_single: assert property (start_rejected |=> !start_rejected)
    else $error("start_rejected longer than one cycle");
  chk_valid_from_busy: assert property (rx_valid |-> $past(rx_busy))
    else $error("character delivered while idle");
  chk_idle_disabled: assert property (!rx_enable [*3] |-> !rx_busy && !rx_valid)
    else $error("receiver active while disabled");
  chk_data_hold: assert property (!rx_valid |-> $stable(rx_data) && $stable(rx_frame_error))
    else $error("character changed without delivery");
  chk_start_low: assert property (frame_open |-> low_age_reg <= 4'hA)
    else $error("frame started without a low line");
  chk_frame_bound: assert property (frame_open |-> frame_closed)
    else $error("frame never completed");
  chk_parity_zero: assert property (rx_valid && !parity_enable |-> !rx_parity)
    else $error("parity reported while disabled");
endmodule : async_rx_monitor

bind async_rx_clock_data_recovery async_rx_monitor #(.DIV_WIDTH(DIV_WIDTH)) u_mon (
  .ref_clk(ref_clk), .rst(rst), .rxd_pin(rxd_pin), .rx_enable(rx_enable),
  .receive_sampling_mode_field(receive_sampling_mode_field), .baud_divider(baud_divider),
  .data_bits(data_bits), .parity_enable(parity_enable), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_parity(rx_parity), .rx_frame_error(rx_frame_error), .start_rejected(start_rejected),
  .rx_busy(rx_busy));

`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the receive front end
// assumes the transmitter model on the pin and a 200 MHz clock
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_crd_pkg::*;

  logic        ref_clk, rst, rx_enable, parity_enable, go, txd, tx_busy;
  logic        rx_valid, rx_parity, rx_frame_error, start_rejected, rx_busy;
  mode_type    mode;
  size_type    data_bits;
  char_type    rx_data;
  logic [15:0] div;
  logic [23:0] bits, short_mask;
  logic [7:0]  bit_clks, short_clks;
  logic [10:0] got_q[$];
  int          err_total, tests_run, n_rej, pos;

  async_rx_clock_data_recovery #(.DIV_WIDTH(16)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .rxd_pin(txd), .rx_enable(rx_enable),
    .receive_sampling_mode_field(mode), .baud_divider(div), .data_bits(data_bits),
    .parity_enable(parity_enable), .rx_valid(rx_valid), .rx_data(rx_data), .rx_parity(rx_parity),
    .rx_frame_error(rx_frame_error), .start_rejected(start_rejected), .rx_busy(rx_busy));

  serial_tx_model u_tx (
    .ref_clk(ref_clk), .go(go), .bits(bits), .short_mask(short_mask), .nbits(5'(pos)),
    .bit_clks(bit_clks), .short_clks(short_clks), .txd(txd), .busy(tx_busy));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // collects delivered characters and rejected starts
  always @(posedge ref_clk) begin
    if (rx_valid)
      got_q.push_back({rx_frame_error, rx_parity, rx_data});
    if (start_rejected)
      n_rej++;
  end

  // ==========================================================
  // compares and verdict
  task automatic cmp_char(input char_type got, input char_type exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask : cmp_char

  task automatic cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic summarize();
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // ==========================================================
  // frame helpers
  task automatic cfg(input mode_type m, input int s, input logic [15:0] dv, input size_type nd, input logic pe);
    @(posedge ref_clk);
    mode <= m;
    div <= dv;
    data_bits <= nd;
    parity_enable <= pe;
    bits = '1;
    short_mask = '0;
    pos = 0;
    bit_clks = 8'((dv + 1) * s);
  endtask : cfg

  task automatic add_char(input logic [8:0] d, input int nd, input logic pe, input logic sb);
    bits[pos] = 1'b0;
    for (int i = 0; i < nd; i++)
      bits[pos + 1 + i] = d[i];
    if (pe)
      bits[pos + 1 + nd] = ^d;
    pos = pos + 2 + nd + int'(pe);
    bits[pos - 1] = sb;
  endtask : add_char

  task automatic launch();
    int t;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (tx_busy && t < 4000);
    if (t >= 4000) begin
      err_total++;
      $display("[FAIL] %0t transmitter model stuck", $time);
    end
    repeat (2 * bit_clks) @(posedge ref_clk);
  endtask : launch

  task automatic expect_char(input logic [8:0] d, input int nd, input logic pe, input logic sb);
    logic [10:0] g;
    if (got_q.size() == 0) begin
      err_total++;
      $display("[FAIL] %0t character missing", $time);
      return;
    end
    g = got_q.pop_front();
    cmp_char(g[8:0], d & 9'((1 << nd) - 1));
    cmp_bit(g[9], pe ? ^d : 1'b0);
    cmp_bit(g[10], ~sb);
  endtask : expect_char

  // ==========================================================
  // scenarios
  task automatic test_modes();
    for (int m = 0; m < 4; m++) begin
      for (int nd = 5; nd < 10; nd++) begin
        cfg(mode_type'(m), (m == 1) ? 8 : 16, 16'h0001, size_type'(nd), nd[0]);
        add_char(9'h1A5 ^ 9'(nd * 37), nd, nd[0], 1'b1);
        launch();
        expect_char(9'h1A5 ^ 9'(nd * 37), nd, nd[0], 1'b1);
      end
    end
  endtask : test_modes

  task automatic test_stop();
    for (int m = 0; m < 2; m++) begin
      cfg(mode_type'(m), 16 >> m, 16'h0001, 4'h8, 1'b0);
      add_char(9'h0C3, 8, 1'b0, 1'b0);
      launch();
      expect_char(9'h0C3, 8, 1'b0, 1'b0);
      cfg(mode_type'(m), 16 >> m, 16'h0001, 4'h8, 1'b0);
      add_char(9'h05A, 8, 1'b0, 1'b1);
      short_mask[pos - 1] = 1'b1;
      short_clks = 8'(m ? 12 : 20);
      add_char(9'h0A5, 8, 1'b0, 1'b1);
      launch();
      expect_char(9'h05A, 8, 1'b0, 1'b1);
      expect_char(9'h0A5, 8, 1'b0, 1'b1);
    end
  endtask : test_stop

  // low pulse one sample short of and just long enough for the vote
  task automatic test_start_vote();
    int r0;
    for (int m = 0; m < 2; m++) begin
      for (int a = 0; a < 2; a++) begin
        cfg(mode_type'(m), 16 >> m, 16'h0000, 4'h8, 1'b0);
        bits[0] = 1'b0;
        pos = 1;
        bit_clks = 8'((m ? 4 : 8) + a);
        r0 = n_rej;
        launch();
        cmp_bit(rx_busy, a[0]);
        repeat (200) @(posedge ref_clk);
        cmp_bit(n_rej == r0 + 1 - a, 1'b1);
        if (a)
          expect_char(9'h0FF, 8, 1'b0, 1'b1);
      end
    end
  endtask : test_start_vote

  task automatic test_disable();
    cfg(MODE_NORMAL, 16, 16'h0001, 4'h8, 1'b0);
    add_char(9'h033, 8, 1'b0, 1'b1);
    rx_enable <= 1'b0;
    launch();
    rx_enable <= 1'b1;
    cmp_bit(got_q.size() == 0, 1'b1);
    launch();
    expect_char(9'h033, 8, 1'b0, 1'b1);
  endtask : test_disable

  initial begin
    rst = 1'b1;
    rx_enable = 1'b0;
    mode = MODE_NORMAL;
    div = 16'h0001;
    data_bits = 4'h8;
    parity_enable = 1'b0;
    go = 1'b0;
    bits = '1;
    short_mask = '0;
    pos = 0;
    bit_clks = 8'h20;
    short_clks = 8'h20;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rx_enable <= 1'b1;
    repeat (4) @(posedge ref_clk);
    test_modes();
    test_stop();
    cmp_bit(got_q.size() == 0, 1'b1);
    test_start_vote();
    test_disable();
    cmp_bit(got_q.size() == 0, 1'b1);
    summarize();
  end

  initial begin
    #400000;
    err_total++;
    summarize();
  end
endmodule : testbench

`default_nettype wire
